// ### logic/fdc_pkg.sv
`default_nettype none
package fdc_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned CLK_NS = 40;
    localparam int unsigned STEP_PULSE_NS = 500;
    localparam int unsigned STEP_CYC = STEP_PULSE_NS / CLK_NS;
    localparam int unsigned INACT_S = 4;
    localparam int unsigned INACT_CYC = INACT_S * CLK_HZ;
    localparam int unsigned TIMER_W = 27;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned BLOCK_W = 10;
    localparam int unsigned ADDR_A0 = 0;
    localparam int unsigned ADDR_A1 = 1;
    localparam int unsigned ADDR_A9 = 9;
    localparam int unsigned CMD_LSB = 5;
    localparam int unsigned BIT_D0 = 0;
    localparam int unsigned BIT_HEAD = 4;
    localparam logic [2:0] CODE_UNIT = 3'h0;
    localparam logic [2:0] CODE_INTR = 3'h1;
    localparam logic [2:0] CODE_STEP = 3'h2;
    localparam logic [2:0] CODE_WRITE = 3'h3;
    localparam logic [2:0] CODE_RESET = 3'h4;
    // status byte 1 bit positions, and the status byte 0 sector flag bit
    localparam int unsigned ST1_SEL_N = 2;
    localparam int unsigned ST1_TRK0 = 3;
    localparam int unsigned ST1_WPROT = 4;
    localparam int unsigned ST1_READY = 5;
    localparam int unsigned ST1_PINTE = 6;
    localparam int unsigned ST1_TF = 7;
    localparam int unsigned ST0_SF = 7;
    // synchroniser lanes
    localparam int unsigned SY_WSYNC = 0;
    localparam int unsigned SY_RSYNC = 1;
    localparam int unsigned SY_SF = 2;
    localparam int unsigned SY_SP_N = 3;
    localparam int unsigned SY_READY = 4;
    localparam int unsigned SY_WBP_N = 5;
    localparam int unsigned SY_RBP_N = 6;
    localparam int unsigned SYNC_W = 7;
    localparam logic [SYNC_W-1:0] SYNC_RST = 7'h78;
    localparam logic [ADDR_W-1:0] BOARD_BASE_DEF = 16'h0000;

    typedef enum logic [1:0] {FDC_BUS_IDLE, FDC_BUS_DONE} fdc_bus_t;
    typedef enum logic [2:0] {
        FDC_CMD_NONE, FDC_CMD_UNIT, FDC_CMD_INTR, FDC_CMD_STEP, FDC_CMD_WRITE, FDC_CMD_RESET
    } fdc_cmd_t;

    function automatic fdc_cmd_t fdc_decode(input logic [2:0] code);
        fdc_cmd_t c;
        c = FDC_CMD_NONE;
        case (code)
            CODE_UNIT: c = FDC_CMD_UNIT;
            CODE_INTR: c = FDC_CMD_INTR;
            CODE_STEP: c = FDC_CMD_STEP;
            CODE_WRITE: c = FDC_CMD_WRITE;
            CODE_RESET: c = FDC_CMD_RESET;
            default: c = FDC_CMD_NONE;
        endcase
        return c;
    endfunction
endpackage
`default_nettype wire

// ### logic/fdc_ctrl.sv
// The Avalon-MM register port and the address map were left to the implementer.
`default_nettype none
module fdc_ctrl #(
    parameter logic [fdc_pkg::ADDR_W-1:0] BOARD_BASE = fdc_pkg::BOARD_BASE_DEF,
    parameter int unsigned TIMEOUT_CYC = fdc_pkg::INACT_CYC
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic poc_n_in,
    input wire logic [fdc_pkg::ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic sinp_in,
    input wire logic sout_in,
    output logic prdy_out,
    output logic prdy_oe_n_out,
    output logic bus_read_gate_n_out,
    input wire logic pinte_in,
    output logic pint_n_out,
    output logic pint_oe_n_out,
    input wire logic [7:0] read_data_in,
    input wire logic [7:0] prom_data_in,
    input wire logic [3:0] sector_count_in,
    input wire logic sector_flag_in,
    input wire logic sector_boundary_pulse_n_in,
    input wire logic write_sync_flag_in,
    input wire logic read_sync_flag_in,
    input wire logic write_byte_pulse_n_in,
    input wire logic read_byte_pulse_n_in,
    input wire logic drive_ready_in,
    input wire logic track0_in,
    input wire logic write_protect_in,
    output logic [3:0] drive_select_out,
    output logic head_select_out,
    output logic step_out,
    output logic step_dir_out,
    output logic write_gate_out,
    output logic write_enable_latch_out,
    output logic transfer_flag_out
);
    import fdc_pkg::*;

    localparam logic [TIMER_W-1:0] TIMER_LOAD = TIMER_W'(TIMEOUT_CYC);
    localparam logic [3:0] STEP_LOAD = 4'(STEP_CYC);

    ////////////////////////////////////////////////////////////////////////////////
    // drive-side synchronisers
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic [SYNC_W-1:0] sync3_r;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sync1_r <= SYNC_RST;
            sync2_r <= SYNC_RST;
            sync3_r <= SYNC_RST;
        end else begin
            sync1_r <= {read_byte_pulse_n_in, write_byte_pulse_n_in, drive_ready_in,
                        sector_boundary_pulse_n_in, sector_flag_in, read_sync_flag_in,
                        write_sync_flag_in};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    logic transfer_flag;
    logic ready_s;
    logic sf_rise;
    logic sp_fall;
    logic byte_pulses_idle;

    assign transfer_flag = sync2_r[SY_WSYNC] | sync2_r[SY_RSYNC];
    assign ready_s = sync2_r[SY_READY];
    assign sf_rise = sync2_r[SY_SF] & ~sync3_r[SY_SF];
    assign sp_fall = ~sync2_r[SY_SP_N] & sync3_r[SY_SP_N];
    assign byte_pulses_idle = sync2_r[SY_WBP_N] & sync2_r[SY_RBP_N];

    ////////////////////////////////////////////////////////////////////////////////
    // address decode and bus handshake
    logic bus_req;
    logic board_select;
    logic controller_select;
    logic data_register_select;
    logic xfer_hold;
    logic accept;
    logic cmd_strobe;
    logic ctl_read;
    fdc_cmd_t cmd;
    logic [7:0] wbyte;

    assign bus_req = avs_read_in | avs_write_in;
    assign board_select = bus_req &&
        (avs_address_in[ADDR_W-1:BLOCK_W] == BOARD_BASE[ADDR_W-1:BLOCK_W]);
    assign controller_select = board_select & ~avs_address_in[ADDR_A9];
    assign data_register_select = controller_select & avs_address_in[ADDR_A1];
    // hold mirrors the ready gate; byte pulse low releases it
    assign xfer_hold = data_register_select & transfer_flag & byte_pulses_idle;

    fdc_bus_t bus_r;
    fdc_bus_t bus_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    assign accept = (bus_r == FDC_BUS_DONE) & bus_req;
    assign cmd_strobe = accept & avs_write_in & controller_select
                        & ~avs_address_in[ADDR_A1];
    assign ctl_read = accept & avs_read_in & controller_select;
    assign wbyte = avs_writedata_in[7:0];
    assign cmd = cmd_strobe ? fdc_decode(wbyte[7:CMD_LSB]) : FDC_CMD_NONE;

    logic drive_selected_flag_r;
    logic [1:0] drive_addr_r;
    logic [7:0] status0;
    logic [7:0] status1;

    always_comb begin
        status0 = 8'h00;
        status0[3:0] = sector_count_in;
        status0[ST0_SF] = sync2_r[SY_SF];
        status1 = 8'h00;
        status1[1:0] = drive_addr_r;
        status1[ST1_SEL_N] = ~drive_selected_flag_r;
        status1[ST1_TRK0] = track0_in;
        status1[ST1_WPROT] = write_protect_in;
        status1[ST1_READY] = ready_s;
        status1[ST1_PINTE] = pinte_in;
        status1[ST1_TF] = transfer_flag;
    end

    always_comb begin
        bus_nxt = FDC_BUS_IDLE;
        rdata_nxt = rdata_r;
        case (bus_r)
            FDC_BUS_IDLE: begin
                // a held data transfer waits here until a byte pulse frees it
                if (bus_req && !xfer_hold) begin
                    bus_nxt = FDC_BUS_DONE;
                    if (!board_select) begin
                        rdata_nxt = 8'h00;
                    end else if (avs_address_in[ADDR_A9]) begin
                        rdata_nxt = prom_data_in;
                    end else if (avs_address_in[ADDR_A1]) begin
                        rdata_nxt = read_data_in;
                    end else if (avs_address_in[ADDR_A0]) begin
                        rdata_nxt = status1;
                    end else begin
                        rdata_nxt = status0;
                    end
                end
            end
            FDC_BUS_DONE: bus_nxt = FDC_BUS_IDLE;
            default: bus_nxt = FDC_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            bus_r <= FDC_BUS_IDLE;
            rdata_r <= 8'h00;
        end else begin
            bus_r <= bus_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_waitrequest_out = bus_req & (bus_r != FDC_BUS_DONE);
    assign avs_readdata_out = {24'h000000, rdata_r};
    assign prdy_oe_n_out = ~(board_select & ~sinp_in & ~sout_in);
    assign prdy_out = ~xfer_hold;
    assign bus_read_gate_n_out = ~(board_select & avs_read_in);

    ////////////////////////////////////////////////////////////////////////////////
    // inactivity timer and general reset
    logic [TIMER_W-1:0] timer_r;
    logic [TIMER_W-1:0] timer_nxt;
    logic timer_expired;
    logic gen_reset;

    assign timer_expired = (timer_r == '0);
    // starts expired, so software must read status or the data register before selecting a drive
    assign gen_reset = timer_expired | (cmd == FDC_CMD_RESET) | ~poc_n_in;

    always_comb begin
        timer_nxt = timer_r;
        if (ctl_read) begin
            timer_nxt = TIMER_LOAD;
        end else if (!timer_expired) begin
            timer_nxt = timer_r - TIMER_W'(1);
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            timer_r <= '0;
        end else begin
            timer_r <= timer_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // unit select, step and write latch
    logic [1:0] drive_addr_nxt;
    logic drive_selected_flag_nxt;
    logic head_r;
    logic head_nxt;
    logic dir_r;
    logic dir_nxt;
    logic [3:0] step_cnt_r;
    logic [3:0] step_cnt_nxt;
    logic wr_trail_r;
    logic wr_trail_nxt;
    logic write_enable_latch_r;
    logic write_enable_latch_nxt;

    always_comb begin
        drive_addr_nxt = drive_addr_r;
        head_nxt = head_r;
        drive_selected_flag_nxt = drive_selected_flag_r;
        dir_nxt = dir_r;
        step_cnt_nxt = step_cnt_r;
        write_enable_latch_nxt = write_enable_latch_r;
        wr_trail_nxt = (cmd == FDC_CMD_WRITE);
        if (gen_reset) begin
            drive_selected_flag_nxt = 1'b0;
        end else if (cmd == FDC_CMD_UNIT) begin
            drive_addr_nxt = wbyte[1:0];
            head_nxt = wbyte[BIT_HEAD];
            drive_selected_flag_nxt = 1'b1;
        end
        if (cmd == FDC_CMD_STEP) begin
            dir_nxt = wbyte[BIT_D0];
            step_cnt_nxt = STEP_LOAD;
        end else if (step_cnt_r != 4'h0) begin
            step_cnt_nxt = step_cnt_r - 4'h1;
        end
        // clearing dominates: a latch left set would write over the next sector
        if (gen_reset || !ready_s || sp_fall) begin
            write_enable_latch_nxt = 1'b0;
        end else if (wr_trail_r) begin
            write_enable_latch_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            drive_addr_r <= 2'h0;
            head_r <= 1'b0;
            drive_selected_flag_r <= 1'b0;
            dir_r <= 1'b0;
            step_cnt_r <= 4'h0;
            wr_trail_r <= 1'b0;
            write_enable_latch_r <= 1'b0;
        end else begin
            drive_addr_r <= drive_addr_nxt;
            head_r <= head_nxt;
            drive_selected_flag_r <= drive_selected_flag_nxt;
            dir_r <= dir_nxt;
            step_cnt_r <= step_cnt_nxt;
            wr_trail_r <= wr_trail_nxt;
            write_enable_latch_r <= write_enable_latch_nxt;
        end
    end

    always_comb begin
        drive_select_out = 4'h0;
        drive_select_out[drive_addr_r] = drive_selected_flag_r;
    end
    assign head_select_out = head_r;
    assign step_out = (step_cnt_r != 4'h0);
    assign step_dir_out = dir_r;
    assign write_gate_out = write_enable_latch_r;
    assign write_enable_latch_out = write_enable_latch_r;
    assign transfer_flag_out = transfer_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // sector interrupt
    logic int_en_r;
    logic int_en_nxt;
    logic int_pend_r;
    logic int_pend_nxt;

    always_comb begin
        int_en_nxt = int_en_r;
        int_pend_nxt = int_pend_r;
        if (gen_reset) begin
            int_en_nxt = 1'b0;
            int_pend_nxt = 1'b0;
        end else begin
            if (cmd == FDC_CMD_INTR) begin
                int_en_nxt = wbyte[BIT_D0];
                if (!wbyte[BIT_D0]) begin
                    int_pend_nxt = 1'b0;
                end
            end
            // a boundary in the clearing cycle is kept
            if (int_en_r && sf_rise) begin
                int_pend_nxt = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            int_en_r <= 1'b0;
            int_pend_r <= 1'b0;
        end else begin
            int_en_r <= int_en_nxt;
            int_pend_r <= int_pend_nxt;
        end
    end

    assign pint_n_out = ~int_pend_r;
    assign pint_oe_n_out = ~int_pend_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    sel_onehot_a: assert property (
        (drive_select_out == 4'h0) || ($onehot(drive_select_out) && drive_selected_flag_r))
        else $error("drive select not one-hot or not gated");
    unit_latch_a: assert property (
        (cmd == FDC_CMD_UNIT && !gen_reset) |=>
        drive_selected_flag_r && drive_addr_r == $past(wbyte[1:0]) &&
        head_select_out == $past(wbyte[BIT_HEAD]))
        else $error("unit address not latched");
    reset_clears_a: assert property (
        gen_reset |=> !drive_selected_flag_r && !int_en_r && !int_pend_r)
        else $error("general reset did not clear state");
    step_pulse_a: assert property (
        (cmd == FDC_CMD_STEP) |=> step_out && step_dir_out == $past(wbyte[BIT_D0])
        ##11 step_out ##1 !step_out)
        else $error("step pulse length wrong");
    write_set_a: assert property (
        (cmd == FDC_CMD_WRITE && !gen_reset && ready_s) ##1
        (!gen_reset && ready_s && !sp_fall) |=> write_gate_out)
        else $error("write latch not set after write command");
    write_clear_a: assert property (
        (gen_reset || !ready_s || sp_fall) |=> !write_gate_out)
        else $error("write latch not cleared");
    timer_retrig_a: assert property (
        ctl_read |=> timer_r == TIMER_LOAD && !timer_expired)
        else $error("inactivity timer not restarted");
    prdy_hold_a: assert property (
        (bus_req && xfer_hold && bus_r == FDC_BUS_IDLE) |-> avs_waitrequest_out && !prdy_out
        ##1 (bus_r == FDC_BUS_IDLE))
        else $error("data transfer not held");
    prdy_oe_a: assert property (
        !prdy_oe_n_out |-> board_select && !sinp_in && !sout_in)
        else $error("ready driven outside memory cycle");
    dig_a: assert property (
        !bus_read_gate_n_out == (avs_read_in &&
        avs_address_in[ADDR_W-1:BLOCK_W] == BOARD_BASE[ADDR_W-1:BLOCK_W]))
        else $error("data-in gate wrong");
    int_set_a: assert property (
        (int_en_r && sf_rise && !gen_reset) |=> !pint_n_out && !pint_oe_n_out)
        else $error("sector interrupt not raised");
    int_clear_a: assert property (
        (cmd == FDC_CMD_INTR && !wbyte[BIT_D0] && !gen_reset && !(int_en_r && sf_rise))
        |=> pint_n_out && !int_en_r)
        else $error("interrupt control did not clear");
    status_sel_a: assert property (
        (ctl_read && !avs_address_in[ADDR_A1] && avs_address_in[ADDR_A0]) |->
        avs_readdata_out[ST1_SEL_N] == !$past(drive_selected_flag_r))
        else $error("selected flag in status wrong");

    step_cov_c: cover property ((cmd == FDC_CMD_STEP) ##1 step_out);
    write_cov_c: cover property (wr_trail_r ##1 write_gate_out);
    int_cov_c: cover property (int_en_r && sf_rise ##1 !pint_n_out);
    xfer_cov_c: cover property (avs_waitrequest_out && xfer_hold ##[1:200] accept);
endmodule
`default_nettype wire

// ### tb/fdc_drv_model.sv
`default_nettype none
module fdc_drv_model (
    input wire logic clk_in,
    input wire logic sec_go_in,
    input wire logic xfer_in,
    output logic sector_flag_out,
    output logic sector_pulse_n_out,
    output logic byte_pulse_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    int sec_cnt = 0;
    int bit_cnt = 0;
    // times scaled down: one bit time is two clocks here, a byte pulse every 16 clocks
    always @(posedge clk_in) begin
        if (sec_go_in) begin
            sec_cnt <= 10;
        end else if (sec_cnt > 0) begin
            sec_cnt <= sec_cnt - 1;
        end
        bit_cnt <= xfer_in ? (bit_cnt + 1) % 16 : 0;
    end
    // flag outlasts the boundary pulse, as the separator does
    assign sector_flag_out = sec_cnt > 0;
    assign sector_pulse_n_out = !(sec_cnt > 6);
    assign byte_pulse_n_out = !(bit_cnt == 15);
endmodule
`default_nettype wire

// ### tb/fdc_ctrl_tb_top.sv
`default_nettype none
module fdc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import fdc_pkg::*;
    localparam int TO = 200;
    logic clk_sys_in = 0, rstn_in = 0, poc_n_in = 1, avs_read_in = 0, avs_write_in = 0;
    logic [15:0] avs_address_in = '0;
    logic [31:0] avs_writedata_in = '0, avs_readdata_out;
    logic avs_waitrequest_out, prdy_out, prdy_oe_n_out, bus_read_gate_n_out;
    logic pint_n_out, pint_oe_n_out, pinte_in = 0, sec_go = 0, sinp_in = 0, sout_in = 0;
    logic [7:0] read_data_in = '0, prom_data_in = '0, q;
    logic [3:0] sector_count_in = '0, drive_select_out;
    logic sector_flag_in, sector_boundary_pulse_n_in, write_byte_pulse_n_in;
    logic write_sync_flag_in = 0, read_sync_flag_in = 0, read_byte_pulse_n_in = 1;
    logic drive_ready_in = 1, track0_in = 0, write_protect_in = 0;
    logic head_select_out, step_out, step_dir_out, write_gate_out;
    logic write_enable_latch_out, transfer_flag_out;
    int n_errors = 0, n_compared = 0, seed = 32'h6c1a812a;

    fdc_drv_model drv (.clk_in(clk_sys_in), .sec_go_in(sec_go), .xfer_in(write_sync_flag_in),
        .sector_flag_out(sector_flag_in), .sector_pulse_n_out(sector_boundary_pulse_n_in),
        .byte_pulse_n_out(write_byte_pulse_n_in));
    fdc_ctrl #(.TIMEOUT_CYC(TO)) dut (.clk_sys_in, .rstn_in, .poc_n_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out,
        .avs_waitrequest_out, .sinp_in, .sout_in, .prdy_out, .prdy_oe_n_out,
        .bus_read_gate_n_out, .pinte_in, .pint_n_out, .pint_oe_n_out, .read_data_in,
        .prom_data_in, .sector_count_in, .sector_flag_in, .sector_boundary_pulse_n_in,
        .write_sync_flag_in, .read_sync_flag_in, .write_byte_pulse_n_in,
        .read_byte_pulse_n_in, .drive_ready_in, .track0_in, .write_protect_in,
        .drive_select_out, .head_select_out, .step_out, .step_dir_out, .write_gate_out,
        .write_enable_latch_out, .transfer_flag_out);

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= {24'h0, d};
        avs_write_in <= w;
        avs_read_in <= !w;
        // hold everything until waitrequest is seen low at an edge
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 100);
        if (n >= 100) n_errors++;
        q = avs_readdata_out[7:0];
        avs_write_in <= 0;
        avs_read_in <= 0;
        @(posedge clk_sys_in);
    endtask
    task automatic cmd(input logic [2:0] c, input logic [4:0] m);
        bus(1, 16'h0000, {c, m});
    endtask
    task automatic sector;
        sec_go <= 1;
        @(posedge clk_sys_in);
        sec_go <= 0;
        repeat (8) @(posedge clk_sys_in);
    endtask
    function automatic logic [7:0] st1(input logic [1:0] dr, input logic sel);
        return {write_sync_flag_in, pinte_in, drive_ready_in, write_protect_in, track0_in,
            !sel, dr};
    endfunction

    initial begin
        forever #20 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_errors++;
        print_verdict();
    end
    initial begin
        logic hd;
        logic dir;
        int n;
        repeat (20) @(posedge clk_sys_in);
        rstn_in <= 1;
        @(posedge clk_sys_in);
        bus(0, 16'h0001, 0);
        chk(q, st1(2'h0, 0));
        for (int i = 0; i < 4; i++) begin
            hd = $random(seed);
            pinte_in <= $random(seed);
            track0_in <= $random(seed);
            write_protect_in <= $random(seed);
            cmd(CODE_UNIT, {hd, 2'h3, i[1:0]});
            chk(drive_select_out, 4'h1 << i);
            chk(head_select_out, hd);
            bus(0, 16'h0001, 0);
            chk(q, st1(i[1:0], 1));
        end
        $display("test select done");
        dir = $random(seed);
        // a single step, so the spacing between steps never comes into play
        cmd(CODE_STEP, {4'h0, dir});
        n = 0;
        while (step_out === 1'b1 && n < 50) begin
            n++;
            @(posedge clk_sys_in);
        end
        chk(n, STEP_CYC);
        chk(step_dir_out, dir);
        $display("test step done");
        bus(0, 16'h0001, 0);
        cmd(CODE_WRITE, 0);
        @(posedge clk_sys_in);
        chk(write_gate_out, 1);
        sector();
        chk(write_enable_latch_out, 0);
        chk(pint_n_out, 1);
        cmd(CODE_WRITE, 0);
        drive_ready_in <= 0;
        repeat (6) @(posedge clk_sys_in);
        chk(write_gate_out, 0);
        drive_ready_in <= 1;
        $display("test write done");
        bus(0, 16'h0001, 0);
        cmd(CODE_INTR, 5'h01);
        sector_count_in <= $random(seed);
        sector();
        chk({pint_n_out, pint_oe_n_out}, 2'b00);
        bus(0, 16'h0000, 0);
        chk(q, {1'b1, 3'h0, sector_count_in});
        cmd(CODE_INTR, 5'h00);
        chk(pint_n_out, 1);
        sector();
        chk(pint_n_out, 1);
        cmd(CODE_INTR, 5'h01);
        cmd(CODE_RESET, 0);
        chk(drive_select_out, 0);
        bus(0, 16'h0001, 0);
        sector();
        chk(pint_n_out, 1);
        $display("test interrupt done");
        write_sync_flag_in <= 1;
        read_data_in <= $random(seed);
        repeat (6) @(posedge clk_sys_in);
        bus(0, 16'h0001, 0);
        chk({q[7], transfer_flag_out}, 2'b11);
        fork
            bus(0, 16'h0002, 0);
            begin
                repeat (3) @(posedge clk_sys_in);
                chk({prdy_out, prdy_oe_n_out}, 2'b00);
                chk(bus_read_gate_n_out, 0);
                // an i/o cycle must release the ready line
                sout_in <= 1;
                @(posedge clk_sys_in);
                chk(prdy_oe_n_out, 1);
                sout_in <= 0;
            end
        join
        chk(q, read_data_in);
        write_sync_flag_in <= 0;
        $display("test transfer done");
        prom_data_in <= $random(seed);
        cmd(CODE_UNIT, 5'h02);
        bus(0, 16'h0200, 0);
        chk(q, prom_data_in);
        bus(0, 16'h0400, 0);
        chk(q, 0);
        bus(1, 16'h0400, 8'h01);
        bus(1, 16'h0002, 8'h01);
        for (int c = 5; c < 8; c++) cmd(c[2:0], 5'h01);
        chk(drive_select_out, 4'h4);
        repeat (TO + 20) @(posedge clk_sys_in);
        chk(drive_select_out, 0);
        bus(0, 16'h0001, 0);
        cmd(CODE_UNIT, 5'h01);
        poc_n_in <= 0;
        repeat (4) @(posedge clk_sys_in);
        poc_n_in <= 1;
        repeat (3) @(posedge clk_sys_in);
        chk(drive_select_out, 0);
        $display("test reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
